// *** rtl/ecl_counter_ctl.sv ***
// How it works
// - external reset ignored while counting impossible; internal reset switch still clears
// - external reset sets its occurred flag and blocks further external resets
// - master raises the clear switch; on that rise the flag drops, reset re-armed
// - latch a or b captures the count only while its enable switch is one
// - a latch sets that input's occurred flag and blocks further captures there
// - rising edge of a latch clear switch drops its flag and re-arms latching
`timescale 1ns/1ps
`default_nettype none
module ecl_counter_ctl #(
   parameter int CNT_W = 32
) (
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   // counter side
   input wire logic [CNT_W-1:0] i_count_value,
   input wire logic i_count_possible,
   input wire logic i_ext_reset,
   input wire logic i_phase_z,
   input wire logic i_latch_a,
   input wire logic i_latch_b,
   output logic o_count_clear,
   output logic o_irq,
   // axi4-lite slave
   input wire logic [7:0] i_axi_awaddr,
   input wire logic i_axi_awvalid,
   output logic o_axi_awready,
   input wire logic [31:0] i_axi_wdata,
   input wire logic [3:0] i_axi_wstrb,
   input wire logic i_axi_wvalid,
   output logic o_axi_wready,
   output logic [1:0] o_axi_bresp,
   output logic o_axi_bvalid,
   input wire logic i_axi_bready,
   input wire logic [7:0] i_axi_araddr,
   input wire logic i_axi_arvalid,
   output logic o_axi_arready,
   output logic [31:0] o_axi_rdata,
   output logic [1:0] o_axi_rresp,
   output logic o_axi_rvalid,
   input wire logic i_axi_rready
);
   localparam int NE = ecl_pkg::NUM_EVT;
   localparam int CW = ecl_pkg::CTRL_W;

   // the captured value must fit one bus word
   if (CNT_W < 1 || CNT_W > 32)
   begin : g_bad_width
      $error("CNT_W must lie between 1 and 32");
   end

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic [CW-1:0] ctrl;
      logic [NE-1:0] mask;
      logic [NE-1:0] irq;
      logic [CNT_W-1:0] lat_a;
      logic [CNT_W-1:0] lat_b;
      logic [3:0] in_prev;   // reset, phase z, latch a, latch b
      logic int_prev;
      logic cnt_clr;
      logic aw_got;
      logic w_got;
      logic [7:0] aw_addr;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } ecl_st_s;

   ecl_st_s st_reg;
   ecl_st_s st_next;
   logic [NE-1:0] evt_flag;
   logic [NE-1:0] evt_fire;
   logic [NE-1:0] evt_trig;
   logic [NE-1:0] evt_en;
   logic [NE-1:0] evt_clr;
   logic [3:0] in_now;
   logic [3:0] in_rise;
   logic rst_src;

   // ************************************************************
   // helpers
   // ************************************************************
   // known register offset, used by both the write and read paths
   function automatic logic ecl_mapped(input logic [7:0] a);
      ecl_mapped = (a == ecl_pkg::OFF_CTRL) || (a == ecl_pkg::OFF_STATUS)
                || (a == ecl_pkg::OFF_IRQ_STAT) || (a == ecl_pkg::OFF_IRQ_MASK)
                || (a == ecl_pkg::OFF_LATCH_A) || (a == ecl_pkg::OFF_LATCH_B)
                || (a == ecl_pkg::OFF_COUNT);
   endfunction : ecl_mapped

   // byte-lane merge of write data into an old value
   function automatic logic [31:0] ecl_merge(input logic [31:0] old, input logic [31:0] d,
                                             input logic [3:0] s);
      for (int i = 0; i < 4; i++)
      begin
         ecl_merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
      end
   endfunction : ecl_merge

   // ************************************************************
   // event slots
   // ************************************************************
   assign in_now = {i_latch_b, i_latch_a, i_phase_z, i_ext_reset};
   assign in_rise = in_now & ~st_reg.in_prev;
   // the reset source is chosen by a switch: the dedicated signal or phase z
   assign rst_src = st_reg.ctrl[ecl_pkg::B_RST_SRC_Z] ? in_rise[1] : in_rise[0];

   // external reset only counts while the counter can count
   assign evt_trig[ecl_pkg::EVT_RST] = rst_src & i_count_possible;
   assign evt_trig[ecl_pkg::EVT_LAT_A] = in_rise[2];
   assign evt_trig[ecl_pkg::EVT_LAT_B] = in_rise[3];
   assign evt_en[ecl_pkg::EVT_RST] = st_reg.ctrl[ecl_pkg::B_EXT_RST_EN];
   assign evt_en[ecl_pkg::EVT_LAT_A] = st_reg.ctrl[ecl_pkg::B_LAT_A_EN];
   assign evt_en[ecl_pkg::EVT_LAT_B] = st_reg.ctrl[ecl_pkg::B_LAT_B_EN];
   assign evt_clr[ecl_pkg::EVT_RST] = st_reg.ctrl[ecl_pkg::B_CLR_RST_FLAG];
   assign evt_clr[ecl_pkg::EVT_LAT_A] = st_reg.ctrl[ecl_pkg::B_CLR_LAT_A_FLAG];
   assign evt_clr[ecl_pkg::EVT_LAT_B] = st_reg.ctrl[ecl_pkg::B_CLR_LAT_B_FLAG];

   for (genvar g = 0; g < NE; g++)
   begin : g_evt
      // one carrier per slot keeps the modport hookup plain
      ecl_evt_if u_evt ();
      assign u_evt.trig = evt_trig[g];
      assign u_evt.enable = evt_en[g];
      assign u_evt.clr_sw = evt_clr[g];
      assign evt_flag[g] = u_evt.flag;
      assign evt_fire[g] = u_evt.fire;
      ecl_oneshot u_os (
         .i_sys_clk(i_sys_clk),
         .i_reset_n(i_reset_n),
         .evt(u_evt.unit)
      );
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign o_count_clear = st_reg.cnt_clr;
   assign o_irq = |(st_reg.irq & st_reg.mask);
   assign o_axi_awready = ~st_reg.aw_got;
   assign o_axi_wready = ~st_reg.w_got;
   assign o_axi_bvalid = st_reg.bvalid;
   assign o_axi_bresp = st_reg.bresp;
   assign o_axi_arready = ~st_reg.rvalid;
   assign o_axi_rvalid = st_reg.rvalid;
   assign o_axi_rresp = st_reg.rresp;
   assign o_axi_rdata = st_reg.rdata;

   // ************************************************************
   // next state: events, bus writes and reads
   // ************************************************************
   always_comb
   begin
      logic [31:0] wv;
      logic [31:0] rv;
      logic int_rise;
      logic [31:0] ov;
      wv = '0;
      rv = '0;
      ov = '0;
      int_rise = 1'b0;
      st_next = st_reg;
      st_next.in_prev = in_now;
      st_next.int_prev = st_reg.ctrl[ecl_pkg::B_INT_RST_EXEC];
      // internal reset acts on the switch rise whatever the count state
      int_rise = st_reg.ctrl[ecl_pkg::B_INT_RST_EXEC] & ~st_reg.int_prev;
      st_next.cnt_clr = evt_fire[ecl_pkg::EVT_RST] | int_rise;
      if (evt_fire[ecl_pkg::EVT_LAT_A])
      begin
         st_next.lat_a = i_count_value;
      end
      if (evt_fire[ecl_pkg::EVT_LAT_B])
      begin
         st_next.lat_b = i_count_value;
      end
      // write address and data are taken in either order
      if (i_axi_awvalid && !st_reg.aw_got)
      begin
         st_next.aw_got = 1'b1;
         st_next.aw_addr = i_axi_awaddr;
      end
      if (i_axi_wvalid && !st_reg.w_got)
      begin
         st_next.w_got = 1'b1;
         st_next.w_data = i_axi_wdata;
         st_next.w_strb = i_axi_wstrb;
      end
      if (st_reg.bvalid && i_axi_bready)
      begin
         st_next.bvalid = 1'b0;
      end
      // sticky interrupt bits: a new event beats a write-one clear
      if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid)
      begin
         wv = ecl_merge(32'h0, st_reg.w_data, st_reg.w_strb);
         st_next.aw_got = 1'b0;
         st_next.w_got = 1'b0;
         st_next.bvalid = 1'b1;
         st_next.bresp = ecl_mapped(st_reg.aw_addr) ? ecl_pkg::RESP_OKAY : ecl_pkg::RESP_SLVERR;
         unique case (st_reg.aw_addr)
            ecl_pkg::OFF_CTRL:
            begin
               ov = ecl_merge({{(32-CW){1'b0}}, st_reg.ctrl}, st_reg.w_data, st_reg.w_strb);
               st_next.ctrl = ov[CW-1:0];
            end
            ecl_pkg::OFF_IRQ_STAT:
            begin
               st_next.irq = st_reg.irq & ~wv[NE-1:0];
            end
            ecl_pkg::OFF_IRQ_MASK:
            begin
               // unstrobed lanes keep the old mask bits
               ov = ecl_merge({{(32-NE){1'b0}}, st_reg.mask}, st_reg.w_data, st_reg.w_strb);
               st_next.mask = ov[NE-1:0];
            end
            default:
            begin
               st_next.irq = st_reg.irq;
            end
         endcase
      end
      st_next.irq = st_next.irq | evt_fire;
      // read channel: one word per request, answered next cycle
      if (st_reg.rvalid && i_axi_rready)
      begin
         st_next.rvalid = 1'b0;
      end
      if (i_axi_arvalid && !st_reg.rvalid)
      begin
         unique case (i_axi_araddr)
            ecl_pkg::OFF_CTRL: rv[CW-1:0] = st_reg.ctrl;
            ecl_pkg::OFF_STATUS: rv[ecl_pkg::B_COUNT_OK:0] = {i_count_possible, evt_flag};
            ecl_pkg::OFF_IRQ_STAT: rv[NE-1:0] = st_reg.irq;
            ecl_pkg::OFF_IRQ_MASK: rv[NE-1:0] = st_reg.mask;
            ecl_pkg::OFF_LATCH_A: rv[CNT_W-1:0] = st_reg.lat_a;
            ecl_pkg::OFF_LATCH_B: rv[CNT_W-1:0] = st_reg.lat_b;
            ecl_pkg::OFF_COUNT: rv[CNT_W-1:0] = i_count_value;
            default: rv = '0;
         endcase
         st_next.rvalid = 1'b1;
         st_next.rdata = rv;
         st_next.rresp = ecl_mapped(i_axi_araddr) ? ecl_pkg::RESP_OKAY : ecl_pkg::RESP_SLVERR;
      end
   end

   // ************************************************************
   // state register
   // ************************************************************
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_reset_n)
      begin
         st_reg <= '0;
         st_reg.ctrl <= ecl_pkg::CTRL_RESET;
         st_reg.mask <= ecl_pkg::EVT_RESET;
         st_reg.irq <= ecl_pkg::EVT_RESET;
      end
      else
      begin
         st_reg <= st_next;
      end
   end
endmodule : ecl_counter_ctl
`default_nettype wire

// *** rtl/ecl_evt_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// one event slot: qualified trigger in, flag and fire out
// ****************************************************************
interface ecl_evt_if;
   logic trig;
   logic enable;
   logic clr_sw;
   logic flag;
   logic fire;
   modport unit (input trig, input enable, input clr_sw, output flag, output fire);
   modport host (output trig, output enable, output clr_sw, input flag, input fire);
endinterface : ecl_evt_if
`default_nettype wire

// *** rtl/ecl_oneshot.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// one-shot gate: fires once, then blocks until the clear switch rises
// ****************************************************************
module ecl_oneshot (
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   ecl_evt_if.unit evt
);
   typedef struct packed {
      logic clr_prev;
      logic flag;
   } ecl_os_s;

   ecl_os_s st_reg;
   ecl_os_s st_next;
   logic clr_rise;

   // the clear switch is sampled every cycle so its rise is seen
   assign clr_rise = evt.clr_sw & ~st_reg.clr_prev;
   // a trigger in the re-arm cycle is kept: the set wins over the clear
   assign evt.fire = evt.trig & evt.enable & (~st_reg.flag | clr_rise);
   assign evt.flag = st_reg.flag;

   // next state of the flag
   always_comb
   begin
      st_next = st_reg;
      st_next.clr_prev = evt.clr_sw;
      if (evt.fire)
      begin
         st_next.flag = 1'b1;
      end
      else if (clr_rise)
      begin
         st_next.flag = 1'b0;
      end
   end

   // state register
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_reset_n)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end
endmodule : ecl_oneshot
`default_nettype wire

// *** rtl/ecl_pkg.sv ***
// ****************************************************************
// encoder counter reset and latch: shared constants
// ****************************************************************
package ecl_pkg;

   // ************************************************************
   // register byte offsets
   // ************************************************************
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h0c;
   localparam logic [7:0] OFF_LATCH_A = 8'h10;
   localparam logic [7:0] OFF_LATCH_B = 8'h14;
   localparam logic [7:0] OFF_COUNT = 8'h18;

   // ************************************************************
   // soft switch bits of the control register
   // ************************************************************
   localparam int CTRL_W = 8;
   localparam int B_EXT_RST_EN = 0;
   localparam int B_RST_SRC_Z = 1;
   localparam int B_LAT_A_EN = 2;
   localparam int B_LAT_B_EN = 3;
   localparam int B_CLR_RST_FLAG = 4;
   localparam int B_CLR_LAT_A_FLAG = 5;
   localparam int B_CLR_LAT_B_FLAG = 6;
   localparam int B_INT_RST_EXEC = 7;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;

   // ************************************************************
   // one-shot event slots, shared by flags, status and interrupts
   // ************************************************************
   localparam int NUM_EVT = 3;
   localparam int EVT_RST = 0;
   localparam int EVT_LAT_A = 1;
   localparam int EVT_LAT_B = 2;
   localparam int B_COUNT_OK = 3; // status bit beside the three flags
   localparam logic [NUM_EVT-1:0] EVT_RESET = 3'h0;

   // ************************************************************
   // axi responses
   // ************************************************************
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : ecl_pkg

// *** sim/ecl_counter_ctl_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module ecl_counter_ctl_assertions (
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   input wire logic i_count_possible,
   input wire logic i_ext_reset,
   input wire logic i_phase_z,
   input wire logic i_latch_a,
   input wire logic i_latch_b,
   input wire logic o_count_clear,
   input wire logic o_irq,
   input wire logic i_axi_awvalid,
   input wire logic o_axi_awready,
   input wire logic i_axi_wvalid,
   input wire logic o_axi_wready,
   input wire logic [1:0] o_axi_bresp,
   input wire logic o_axi_bvalid,
   input wire logic i_axi_bready,
   input wire logic i_axi_arvalid,
   input wire logic o_axi_arready,
   input wire logic o_axi_rvalid,
   input wire logic i_axi_rready
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_reset_n);
   logic [3:0] prev_reg;
   logic bv_reg;
   logic ext_ev;
   logic any_ev;
   logic bv_rise;
   // edge memory cleared by reset, as the unit does, so a line high at release counts
   always_ff @(posedge i_sys_clk)
   begin
      prev_reg <= i_reset_n ? {i_latch_b, i_latch_a, i_phase_z, i_ext_reset} : 4'h0;
      bv_reg <= i_reset_n & o_axi_bvalid;
   end
   // rising edges seen this cycle; external reset also needs counting possible
   assign ext_ev = i_count_possible & ((i_ext_reset & ~prev_reg[0]) | (i_phase_z & ~prev_reg[1]));
   assign any_ev = |({i_latch_b, i_latch_a, i_phase_z, i_ext_reset} & ~prev_reg);
   assign bv_rise = o_axi_bvalid & ~bv_reg;
   property p_clr_once;
      o_count_clear |=> !o_count_clear;
   endproperty
   a_clr_once: assert property (p_clr_once) else $error("count clear longer than one cycle");
   property p_clr_cause;
      o_count_clear |-> $past(ext_ev) || $past(bv_rise);
   endproperty
   a_clr_cause: assert property (p_clr_cause) else $error("count clear without a cause");
   property p_irq_cause;
      $rose(o_irq) |-> $past(any_ev) || bv_rise;
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("irq rose without event or write");
   property p_wr_ans;
      i_axi_awvalid && o_axi_awready && i_axi_wvalid && o_axi_wready && !o_axi_bvalid |-> ##2 o_axi_bvalid;
   endproperty
   a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
   property p_b_drop;
      o_axi_bvalid && i_axi_bready |=> !o_axi_bvalid;
   endproperty
   a_b_drop: assert property (p_b_drop) else $error("bvalid stayed after bready");
   property p_ar_ans;
      i_axi_arvalid && o_axi_arready |=> o_axi_rvalid;
   endproperty
   a_ar_ans: assert property (p_ar_ans) else $error("read answer late");
   property p_r_drop;
      o_axi_rvalid && i_axi_rready |=> !o_axi_rvalid && o_axi_arready;
   endproperty
   a_r_drop: assert property (p_r_drop) else $error("rvalid stayed after rready");
   property p_ar_low;
      o_axi_rvalid |-> !o_axi_arready;
   endproperty
   a_ar_low: assert property (p_ar_low) else $error("arready high with read pending");
   c_clear: cover property (o_count_clear);
   c_irq: cover property ($rose(o_irq));
   c_slverr: cover property (o_axi_bvalid && o_axi_bresp == 2'h2);
endmodule : ecl_counter_ctl_assertions
bind ecl_counter_ctl ecl_counter_ctl_assertions u_chk (.*);
`default_nettype wire

// *** sim/ecl_enc_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// encoder and control lines; the count only moves when the unit clears it or the bench sets it
module ecl_enc_model (
   input wire logic i_sys_clk,
   input wire logic i_count_clear,
   output logic [31:0] o_count_value,
   output logic o_count_possible,
   output logic [3:0] o_lines
);
   initial
   begin
      o_count_value = 32'h0;
      o_count_possible = 1'b1;
      o_lines = 4'h0;
   end
   // counter obeys the clear pulse one edge after it shows
   always @(posedge i_sys_clk)
      if (i_count_clear)
         o_count_value <= 32'h0;
   task automatic set_cnt(input logic [31:0] v);
      @(posedge i_sys_clk);
      o_count_value <= v;
   endtask : set_cnt
   task automatic set_ok(input logic v);
      @(posedge i_sys_clk);
      o_count_possible <= v;
   endtask : set_ok
   // two cycle pulse: 0 ext reset, 1 phase z, 2 latch a, 3 latch b
   task automatic pulse(input int k);
      @(posedge i_sys_clk);
      o_lines[k] <= 1'b1;
      repeat (2) @(posedge i_sys_clk);
      o_lines[k] <= 1'b0;
      repeat (3) @(posedge i_sys_clk);
   endtask : pulse
endmodule : ecl_enc_model
`default_nettype wire

// *** sim/test_encoder_counter_reset_latch.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_encoder_counter_reset_latch;
   logic i_sys_clk = 1'b0;
   logic i_reset_n;
   logic [7:0] i_axi_awaddr;
   logic i_axi_awvalid;
   logic [31:0] i_axi_wdata;
   logic [3:0] i_axi_wstrb;
   logic i_axi_wvalid;
   logic i_axi_bready;
   logic [7:0] i_axi_araddr;
   logic i_axi_arvalid;
   logic i_axi_rready;
   logic o_axi_awready, o_axi_wready, o_axi_bvalid, o_axi_arready, o_axi_rvalid, o_count_clear, o_irq;
   logic [1:0] o_axi_bresp, o_axi_rresp;
   logic [31:0] o_axi_rdata, i_count_value;
   logic i_count_possible;
   logic [3:0] lines;
   int fails = 0;
   int tests_run = 0;
   always #2 i_sys_clk = ~i_sys_clk;
   ecl_enc_model u_enc (.i_sys_clk(i_sys_clk), .i_count_clear(o_count_clear), .o_count_value(i_count_value),
      .o_count_possible(i_count_possible), .o_lines(lines));
   ecl_counter_ctl #(.CNT_W(32)) DUT (
      .i_sys_clk(i_sys_clk),
      .i_reset_n(i_reset_n),
      .i_count_value(i_count_value),
      .i_count_possible(i_count_possible),
      .i_ext_reset(lines[0]),
      .i_phase_z(lines[1]),
      .i_latch_a(lines[2]),
      .i_latch_b(lines[3]),
      .o_count_clear(o_count_clear),
      .o_irq(o_irq),
      .i_axi_awaddr(i_axi_awaddr),
      .i_axi_awvalid(i_axi_awvalid),
      .o_axi_awready(o_axi_awready),
      .i_axi_wdata(i_axi_wdata),
      .i_axi_wstrb(i_axi_wstrb),
      .i_axi_wvalid(i_axi_wvalid),
      .o_axi_wready(o_axi_wready),
      .o_axi_bresp(o_axi_bresp),
      .o_axi_bvalid(o_axi_bvalid),
      .i_axi_bready(i_axi_bready),
      .i_axi_araddr(i_axi_araddr),
      .i_axi_arvalid(i_axi_arvalid),
      .o_axi_arready(o_axi_arready),
      .o_axi_rdata(o_axi_rdata),
      .o_axi_rresp(o_axi_rresp),
      .o_axi_rvalid(o_axi_rvalid),
      .i_axi_rready(i_axi_rready)
   );
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic final_report;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : final_report
   // a bounded wait that runs out ends the run through the report
   task automatic give_up(input int n);
      if (n >= 50)
      begin
         fails++;
         $display("CHECK FAILED handshake expected answer within 50 cycles seen none");
         final_report();
      end
   endtask : give_up
   // addresses above the count word are unmapped and answer with a slave error
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_sys_clk);
      i_axi_awaddr <= a;
      i_axi_wdata <= d;
      i_axi_awvalid <= 1'b1;
      i_axi_wvalid <= 1'b1;
      i_axi_bready <= 1'b1;
      do
      begin
         @(posedge i_sys_clk);
         n++;
         if (o_axi_awready) i_axi_awvalid <= 1'b0;
         if (o_axi_wready) i_axi_wvalid <= 1'b0;
      end
      while (!o_axi_bvalid && n < 50);
      i_axi_bready <= 1'b0;
      give_up(n);
      chk("bresp", {30'h0, o_axi_bresp}, {30'h0, a > 8'h18 ? ecl_pkg::RESP_SLVERR : ecl_pkg::RESP_OKAY});
      repeat (3) @(posedge i_sys_clk);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      int n;
      n = 0;
      @(posedge i_sys_clk);
      i_axi_araddr <= a;
      i_axi_arvalid <= 1'b1;
      i_axi_rready <= 1'b1;
      do
      begin
         @(posedge i_sys_clk);
         n++;
         if (o_axi_arready) i_axi_arvalid <= 1'b0;
      end
      while (!o_axi_rvalid && n < 50);
      i_axi_rready <= 1'b0;
      give_up(n);
      chk($sformatf("read %h", a), o_axi_rdata & m, e);
      chk("rresp", {30'h0, o_axi_rresp}, {30'h0, a > 8'h18 ? ecl_pkg::RESP_SLVERR : ecl_pkg::RESP_OKAY});
   endtask : rd
   task automatic t_basic;
      rd(8'h00, 32'hff, 32'h0);
      rd(8'h04, 32'hf, 32'h8);
      rd(8'h1c, '1, 32'h0);
      wr(8'h1c, 32'h1);
      // no strobed lane: the control word must stay as it was
      i_axi_wstrb <= 4'h0;
      wr(8'h00, 32'hff);
      i_axi_wstrb <= 4'hf;
      rd(8'h00, 32'hff, 32'h0);
      $display("test basic done");
   endtask : t_basic
   task automatic t_ext;
      u_enc.set_cnt(32'h55);
      u_enc.pulse(0);
      rd(8'h18, '1, 32'h55);
      wr(8'h00, 32'h01);
      u_enc.pulse(0);
      rd(8'h18, '1, 32'h0);
      rd(8'h04, 32'h1, 32'h1);
      u_enc.set_cnt(32'h66);
      u_enc.pulse(0);
      rd(8'h18, '1, 32'h66);
      wr(8'h00, 32'h11);
      rd(8'h04, 32'h1, 32'h0);
      wr(8'h00, 32'h03);
      u_enc.set_cnt(32'h44);
      u_enc.pulse(0);
      rd(8'h18, '1, 32'h44);
      u_enc.pulse(1);
      rd(8'h18, '1, 32'h0);
      $display("test external reset done");
   endtask : t_ext
   task automatic t_nocount;
      wr(8'h00, 32'h13);
      u_enc.set_ok(1'b0);
      u_enc.set_cnt(32'h77);
      u_enc.pulse(1);
      rd(8'h18, '1, 32'h77);
      rd(8'h04, 32'h9, 32'h0);
      wr(8'h00, 32'h93);
      rd(8'h18, '1, 32'h0);
      u_enc.set_ok(1'b1);
      $display("test counting stopped done");
   endtask : t_nocount
   task automatic t_latch;
      for (int i = 0; i < 2; i++)
      begin
         u_enc.set_cnt(32'h100 + i);
         u_enc.pulse(2 + i);
         rd(8'h04, 32'h2 << i, 32'h0);
         wr(8'h00, 32'h4 << i);
         u_enc.pulse(2 + i);
         rd(8'h10 + 8'(4 * i), '1, 32'h100 + i);
         rd(8'h04, 32'h2 << i, 32'h2 << i);
         u_enc.set_cnt(32'h200);
         u_enc.pulse(2 + i);
         rd(8'h10 + 8'(4 * i), '1, 32'h100 + i);
         wr(8'h00, 32'h24 << i);
         rd(8'h04, 32'h2 << i, 32'h0);
         u_enc.pulse(2 + i);
         rd(8'h10 + 8'(4 * i), '1, 32'h200);
      end
      $display("test latch done");
   endtask : t_latch
   task automatic t_irq;
      wr(8'h0c, 32'h0);
      chk("irq", {31'h0, o_irq}, 32'h0);
      wr(8'h0c, 32'h7);
      chk("irq", {31'h0, o_irq}, 32'h1);
      rd(8'h08, 32'h7, 32'h7);
      wr(8'h08, 32'h7);
      rd(8'h08, 32'h7, 32'h0);
      chk("irq", {31'h0, o_irq}, 32'h0);
      $display("test interrupt done");
   endtask : t_irq
   initial
   begin
      // idle bus levels before the first edge; reset is held meanwhile
      i_reset_n <= 1'b0;
      i_axi_awaddr <= 8'h00;
      i_axi_awvalid <= 1'b0;
      i_axi_wdata <= 32'h0;
      i_axi_wstrb <= 4'hf;
      i_axi_wvalid <= 1'b0;
      i_axi_bready <= 1'b0;
      i_axi_araddr <= 8'h00;
      i_axi_arvalid <= 1'b0;
      i_axi_rready <= 1'b0;
      repeat (5) @(posedge i_sys_clk);
      i_reset_n <= 1'b1;
      t_basic();
      t_ext();
      t_nocount();
      t_latch();
      t_irq();
      final_report();
   end
endmodule : test_encoder_counter_reset_latch
`default_nettype wire
